// ---- rtl/icp_capture.sv ----
module icp_capture (
    input wire logic clk_sys,
    input wire logic rst,
    input wire icp_pkg::icp_bus_req_s bus_req,
    output logic [15:0] bus_rdata,
    input wire logic capture_input_pin,
    input wire logic [7:0] time_base_ticks,
    input wire logic [31:0] sync_events,
    input wire logic [31:0] sync_sources_on,
    input wire logic cpu_idle,
    input wire logic module_is_odd,
    input wire icp_pkg::icp_casc_s casc_in,
    output icp_pkg::icp_casc_s casc_out,
    output logic capture_irq
);
    import icp_pkg::*;

    // =========================================================
    // Registers
    logic [15:0] ctrl_one_r;
    logic [15:0] ctrl_two_r;
    logic trig_status_r;
    logic ovf_r;
    logic [15:0] cnt_r;
    logic [15:0] fifo_mem [ICP_FIFO_DEPTH];
    logic [1:0] wr_ptr_r;
    logic [1:0] rd_ptr_r;
    logic [2:0] fill_r;
    logic pin_d_r;
    logic [3:0] pre_cnt_r;
    logic [1:0] irq_cnt_r;
    logic [15:0] rdata_r;
    logic irq_r;
    icp_casc_s casc_r;

    // =========================================================
    // Field decode
    icp_mode_e mode;
    logic [2:0] tsel;
    logic [1:0] captures_per_interrupt;
    logic stop_idle;
    logic cascade;
    logic trig_sel;
    logic [4:0] ssel;
    logic even_slave;
    icp_op_e op;

    assign mode = icp_mode_e'(ctrl_one_r[ICP_C1_MODE_LSB +: 3]);
    assign tsel = ctrl_one_r[ICP_C1_TSEL_LSB +: 3];
    assign captures_per_interrupt = ctrl_one_r[ICP_C1_ICI_LSB +: 2];
    assign stop_idle = ctrl_one_r[ICP_C1_IDLE_BIT];
    assign cascade = ctrl_two_r[ICP_C2_CASC_BIT];
    assign trig_sel = ctrl_two_r[ICP_C2_TRIG_BIT];
    assign ssel = ctrl_two_r[ICP_C2_SSEL_LSB +: 5];
    // Even half of a pair follows the odd half when its trigger bit is clear
    assign even_slave = cascade && !module_is_odd && !trig_sel;

    function automatic icp_op_e op_decode(input logic [4:0] sel, input logic trg);
        if (sel == ICP_SSEL_NONE) begin
            op_decode = trg ? ICP_OP_SWTRIG : ICP_OP_FREE;
        end else begin
            op_decode = trg ? ICP_OP_TRIG : ICP_OP_SYNC;
        end
    endfunction : op_decode

    assign op = op_decode(ssel, trig_sel);

    // =========================================================
    // Enables
    logic halted;
    logic tick;
    logic src_event;
    logic src_ready;
    logic running;
    logic cnt_clear;

    assign halted = (mode == ICP_MODE_OFF) || (stop_idle && cpu_idle);
    // Code 111 ticks every cycle; other codes take the external enable pulse
    assign tick = even_slave ? casc_in.wrap
                : (tsel == ICP_TSEL_SYSCLK) ? 1'b1 : time_base_ticks[tsel];
    assign src_event = (ssel != ICP_SSEL_NONE) && sync_events[ssel];
    // A disabled sync source keeps the counter in reset; in trigger mode it only stops the counter
    assign src_ready = (ssel == ICP_SSEL_NONE) || sync_sources_on[ssel];

    always_comb begin
        running = 1'b0;
        cnt_clear = 1'b0;
        if (even_slave) begin
            running = src_ready;
            cnt_clear = casc_in.clear || !src_ready;
        end else begin
            case (op)
                ICP_OP_FREE: begin
                    running = 1'b1;
                end
                ICP_OP_SYNC: begin
                    running = src_ready;
                    cnt_clear = src_event || !src_ready;
                end
                ICP_OP_TRIG: begin
                    running = trig_status_r && src_ready;
                end
                ICP_OP_SWTRIG: begin
                    running = trig_status_r;
                end
                default: begin
                    running = 1'b0;
                end
            endcase
        end
        if (halted) begin
            running = 1'b0;
        end
    end

    // =========================================================
    // Bus decode
    logic wr_one;
    logic wr_two;
    logic wr_cnt;
    logic pop;

    assign wr_one = bus_req.wr && (bus_req.addr == ICP_OFS_CTRL_ONE);
    assign wr_two = bus_req.wr && (bus_req.addr == ICP_OFS_CTRL_TWO);
    assign wr_cnt = bus_req.wr && (bus_req.addr == ICP_OFS_COUNTER);
    assign pop = bus_req.rd && (bus_req.addr == ICP_OFS_FIFO_OUT) && (fill_r != 3'h0);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_one_r <= ICP_C1_RESET;
            ctrl_two_r <= ICP_C2_RESET;
        end else begin
            if (wr_one) begin
                ctrl_one_r <= bus_req.wdata & ICP_C1_WMASK;
            end
            if (wr_two) begin
                ctrl_two_r <= bus_req.wdata & ICP_C2_WMASK;
            end
        end
    end

    // Hardware set of trigger status wins over a software clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_status_r <= 1'b0;
        end else if (op == ICP_OP_TRIG && src_event && !halted) begin
            trig_status_r <= 1'b1;
        end else if (wr_two) begin
            trig_status_r <= bus_req.wdata[ICP_C2_TSTAT_BIT];
        end
    end

    // =========================================================
    // Private counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= ICP_CNT_RESET;
        end else if (wr_cnt) begin
            cnt_r <= bus_req.wdata;
        end else if (cnt_clear) begin
            cnt_r <= ICP_CNT_RESET;
        end else if (running && tick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // =========================================================
    // Edge qualification
    logic rise;
    logic fall;
    logic edge_hit;
    logic pre_last;
    logic cap_event;

    assign rise = capture_input_pin && !pin_d_r;
    assign fall = !capture_input_pin && pin_d_r;
    assign pre_last = (mode == ICP_MODE_PRE4) ? (pre_cnt_r == ICP_PRE4_LAST)
                                              : (pre_cnt_r == ICP_PRE16_LAST);

    always_comb begin
        case (mode)
            ICP_MODE_BOTH: edge_hit = rise || fall;
            ICP_MODE_FALL: edge_hit = fall;
            ICP_MODE_RISE: edge_hit = rise;
            ICP_MODE_PRE4: edge_hit = rise && pre_last;
            ICP_MODE_PRE16: edge_hit = rise && pre_last;
            ICP_MODE_WAKE: edge_hit = rise;
            default: edge_hit = 1'b0;
        endcase
    end

    // Even half captures with its odd partner so the two words pair up
    assign cap_event = even_slave ? (casc_in.capture && !halted)
                                  : (edge_hit && running);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_d_r <= 1'b0;
        end else begin
            pin_d_r <= capture_input_pin;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_cnt_r <= 4'h0;
        end else if (mode != ICP_MODE_PRE4 && mode != ICP_MODE_PRE16) begin
            pre_cnt_r <= 4'h0;
        end else if (rise && running) begin
            pre_cnt_r <= pre_last ? 4'h0 : pre_cnt_r + 4'h1;
        end
    end

    // =========================================================
    // Capture FIFO
    logic full;
    logic push;

    assign full = (fill_r == 3'(ICP_FIFO_DEPTH));
    assign push = cap_event && (!full || pop);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            fifo_mem[wr_ptr_r] <= cnt_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            fill_r <= 3'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            if (push && !pop) begin
                fill_r <= fill_r + 3'h1;
            end else if (pop && !push) begin
                fill_r <= fill_r - 3'h1;
            end
        end
    end

    // A capture into a full FIFO is dropped and sets overflow, unless a pop frees a slot in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovf_r <= 1'b0;
        end else if (cap_event && full && !pop) begin
            ovf_r <= 1'b1;
        end else if (pop || mode == ICP_MODE_OFF) begin
            ovf_r <= 1'b0;
        end
    end

    // =========================================================
    // Captures per interrupt
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_cnt_r <= 2'h0;
            irq_r <= 1'b0;
        end else if (mode == ICP_MODE_OFF) begin
            irq_cnt_r <= 2'h0;
            irq_r <= 1'b0;
        end else begin
            irq_r <= 1'b0;
            if (cap_event) begin
                if (irq_cnt_r == captures_per_interrupt) begin
                    irq_cnt_r <= 2'h0;
                    irq_r <= 1'b1;
                end else begin
                    irq_cnt_r <= irq_cnt_r + 2'h1;
                end
            end
        end
    end

    // =========================================================
    // Cascade pulses toward the even partner, one cycle late on all three
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            casc_r <= '0;
        end else begin
            casc_r.wrap <= cascade && running && tick && !cnt_clear
                           && (cnt_r == ICP_CNT_MAX);
            casc_r.clear <= cascade && cnt_clear;
            casc_r.capture <= cascade && cap_event;
        end
    end

    // =========================================================
    // Read data, valid in the cycle after the strobe
    logic [15:0] c1_view;
    logic [15:0] c2_view;

    always_comb begin
        c1_view = ctrl_one_r;
        c1_view[ICP_C1_OVF_BIT] = ovf_r;
        c1_view[ICP_C1_BNE_BIT] = (fill_r != 3'h0);
        c2_view = ctrl_two_r;
        c2_view[ICP_C2_TSTAT_BIT] = trig_status_r;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ICP_OFS_CTRL_ONE: rdata_r <= c1_view;
                ICP_OFS_CTRL_TWO: rdata_r <= c2_view;
                // Empty FIFO reads as zero and pops nothing
                ICP_OFS_FIFO_OUT: rdata_r <= (fill_r != 3'h0) ? fifo_mem[rd_ptr_r] : 16'h0000;
                ICP_OFS_COUNTER: rdata_r <= cnt_r;
                default: rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    assign bus_rdata = rdata_r;
    assign capture_irq = irq_r;
    assign casc_out = casc_r;

endmodule : icp_capture

// ---- common/icp_pkg.sv ----
package icp_pkg;

    // =========================================================
    // Register map (byte offsets on the plain register port)
    localparam logic [7:0] ICP_OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] ICP_OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] ICP_OFS_FIFO_OUT = 8'h08;
    localparam logic [7:0] ICP_OFS_COUNTER = 8'h0c;

    // =========================================================
    // capture_control_one fields
    localparam int ICP_C1_IDLE_BIT = 13;
    localparam int ICP_C1_TSEL_LSB = 10;
    localparam int ICP_C1_ICI_LSB = 5;
    localparam int ICP_C1_OVF_BIT = 4;
    localparam int ICP_C1_BNE_BIT = 3;
    localparam int ICP_C1_MODE_LSB = 0;
    localparam logic [15:0] ICP_C1_WMASK = 16'h3c67;
    localparam logic [15:0] ICP_C1_RESET = 16'h0000;

    // =========================================================
    // capture_control_two fields
    localparam int ICP_C2_CASC_BIT = 8;
    localparam int ICP_C2_TRIG_BIT = 7;
    localparam int ICP_C2_TSTAT_BIT = 6;
    localparam int ICP_C2_SSEL_LSB = 0;
    localparam logic [15:0] ICP_C2_WMASK = 16'h01df;
    localparam logic [15:0] ICP_C2_RESET = 16'h000d;

    // =========================================================
    // Encodings and sizes
    localparam logic [2:0] ICP_TSEL_SYSCLK = 3'h7;
    localparam logic [4:0] ICP_SSEL_NONE = 5'h00;
    localparam int ICP_FIFO_DEPTH = 4;
    localparam logic [15:0] ICP_CNT_MAX = 16'hffff;
    localparam logic [15:0] ICP_CNT_RESET = 16'h0000;
    localparam logic [3:0] ICP_PRE4_LAST = 4'h3;
    localparam logic [3:0] ICP_PRE16_LAST = 4'hf;

    typedef enum logic [2:0] {
        ICP_MODE_OFF = 3'h0,
        ICP_MODE_BOTH = 3'h1,
        ICP_MODE_FALL = 3'h2,
        ICP_MODE_RISE = 3'h3,
        ICP_MODE_PRE4 = 3'h4,
        ICP_MODE_PRE16 = 3'h5,
        ICP_MODE_RSVD = 3'h6,
        ICP_MODE_WAKE = 3'h7
    } icp_mode_e;

    typedef enum logic [1:0] {
        ICP_OP_FREE,
        ICP_OP_SYNC,
        ICP_OP_TRIG,
        ICP_OP_SWTRIG
    } icp_op_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } icp_bus_req_s;

    // Pulses between the odd (low word) and even (high word) partner
    typedef struct packed {
        logic wrap;
        logic clear;
        logic capture;
    } icp_casc_s;

endpackage : icp_pkg

// ---- tb/icp_pulse_src.sv ----
module icp_pulse_src (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic fire,
    output logic pin
);
    logic [1:0] left_r;

    // ==========================================
    // Pulse shaper
    // Two-cycle high pulse per request; idles low so edges stay countable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            left_r <= 2'h0;
        end else if (fire) begin
            left_r <= 2'h2;
        end else if (left_r != 2'h0) begin
            left_r <= left_r - 2'h1;
        end
    end
    assign pin = (left_r != 2'h0);
endmodule : icp_pulse_src

// ---- tb/icp_capture_assertions.sv ----
module icp_capture_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire icp_pkg::icp_bus_req_s bus_req,
    input wire logic [15:0] bus_rdata,
    input wire logic capture_input_pin,
    input wire logic [7:0] time_base_ticks,
    input wire logic [31:0] sync_events,
    input wire logic [31:0] sync_sources_on,
    input wire logic cpu_idle,
    input wire logic module_is_odd,
    input wire icp_pkg::icp_casc_s casc_in,
    input wire icp_pkg::icp_casc_s casc_out,
    input wire logic capture_irq
);
    import icp_pkg::*;
    logic [15:0] c1_r;
    logic casc_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ==========================================
    // Shadows of written control fields
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            c1_r <= ICP_C1_RESET;
        end else if (bus_req.wr && bus_req.addr == ICP_OFS_CTRL_ONE) begin
            c1_r <= bus_req.wdata & ICP_C1_WMASK;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            casc_r <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == ICP_OFS_CTRL_TWO) begin
            casc_r <= bus_req.wdata[ICP_C2_CASC_BIT];
        end
    end

    // ==========================================
    // Properties
    sequence s_wr(a);
        bus_req.wr && bus_req.addr == a;
    endsequence
    sequence s_rd(a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    sequence s_gap;
        !bus_req.wr && !bus_req.rd;
    endsequence
    property p_c1_back;
        s_wr(ICP_OFS_CTRL_ONE) ##1 s_gap ##1 s_rd(ICP_OFS_CTRL_ONE) |=>
            (bus_rdata & ICP_C1_WMASK) == ($past(bus_req.wdata, 3) & ICP_C1_WMASK);
    endproperty
    property p_c2_back;
        s_wr(ICP_OFS_CTRL_TWO) ##1 s_gap ##1 s_rd(ICP_OFS_CTRL_TWO) |=>
            (bus_rdata & 16'h019f) == ($past(bus_req.wdata, 3) & 16'h019f);
    endproperty
    property p_c1_rsvd;
        s_rd(ICP_OFS_CTRL_ONE) |=> (bus_rdata & ~(ICP_C1_WMASK | 16'h0018)) == 16'h0000;
    endproperty
    property p_idle_zero;
        !bus_req.rd |=> bus_rdata == 16'h0000;
    endproperty
    property p_casc_quiet;
        !casc_r [*2] |-> casc_out == 3'h0;
    endproperty
    property p_irq_gap;
        capture_irq && c1_r[6:5] == 2'h1 |=> !capture_irq;
    endproperty
    property p_irq_off;
        (c1_r[2:0] == 3'h0) [*3] |-> !capture_irq;
    endproperty
    property p_fifo_empty;
        s_rd(ICP_OFS_CTRL_ONE) ##1 (!bus_rdata[3] && c1_r[2:0] == 3'h0)
            ##1 s_rd(ICP_OFS_FIFO_OUT) |=> bus_rdata == 16'h0000;
    endproperty
    a_c1_back: assert property (p_c1_back) else $error("ctrl one readback");
    a_c2_back: assert property (p_c2_back) else $error("ctrl two readback");
    a_c1_rsvd: assert property (p_c1_rsvd) else $error("ctrl one spare bits");
    a_idle_zero: assert property (p_idle_zero) else $error("read data stale");
    a_casc_quiet: assert property (p_casc_quiet) else $error("cascade pulses");
    a_irq_gap: assert property (p_irq_gap) else $error("irq too close");
    a_irq_off: assert property (p_irq_off) else $error("irq while off");
    a_fifo_empty: assert property (p_fifo_empty) else $error("empty fifo data");
endmodule : icp_capture_assertions

bind icp_capture icp_capture_assertions u_chk (.clk_sys(clk_sys), .rst(rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .capture_input_pin(capture_input_pin),
    .time_base_ticks(time_base_ticks), .sync_events(sync_events),
    .sync_sources_on(sync_sources_on), .cpu_idle(cpu_idle), .module_is_odd(module_is_odd),
    .casc_in(casc_in), .casc_out(casc_out), .capture_irq(capture_irq));

// ---- tb/icp_capture_test.sv ----
module icp_capture_test;
    timeunit 1ns;
    timeprecision 1ps;
    import icp_pkg::*;
    logic clk_sys;
    logic rst;
    icp_bus_req_s bus_req;
    logic [15:0] bus_rdata;
    logic pin;
    logic fire;
    logic [7:0] ticks;
    logic [31:0] sev;
    logic [31:0] son;
    logic idle;
    logic idle_hold;
    icp_casc_s casc_out;
    logic irq;
    int errors;
    int checks_done;
    int irqs = 0;
    int wraps = 0;
    int base;
    int seed;
    int n;
    int g [4];
    logic [15:0] d;
    logic [15:0] v [8];
    int mt [6] = '{1, 2, 3, 4, 5, 0};
    int pt [6] = '{2, 3, 3, 8, 16, 3};

    icp_capture uut (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .capture_input_pin(pin), .time_base_ticks(ticks), .sync_events(sev),
        .sync_sources_on(son), .cpu_idle(idle), .module_is_odd(1'b1), .casc_in(3'h0),
        .casc_out(casc_out), .capture_irq(irq));
    icp_pulse_src u_src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .pin(pin));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================
    // Background stimulus and event counters
    always @(posedge clk_sys) begin
        ticks <= $random(seed);
        idle <= idle_hold | ticks[0];
        if (irq === 1'b1) irqs <= irqs + 1;
        if (casc_out.wrap === 1'b1) wraps <= wraps + 1;
    end

    // ==========================================
    // Expectations and shared tasks
    function automatic int exp_caps(input int m, input int p);
        int c;
        c = (m == 1) ? 2 * p : (m == 2 || m == 3) ? p : (m == 4) ? p / 4 : (m == 5) ? p / 16 : 0;
        return (c > ICP_FIFO_DEPTH) ? ICP_FIFO_DEPTH : c;
    endfunction : exp_caps
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] r);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        #1 r = bus_rdata;
    endtask : rd
    task automatic ctr_step(output logic [15:0] st);
        logic [15:0] a;
        logic [15:0] b;
        rd(ICP_OFS_COUNTER, a);
        rd(ICP_OFS_COUNTER, b);
        st = b - a;
    endtask : ctr_step
    task automatic fire_n(input int cnt, input int gap);
        repeat (cnt) begin
            @(posedge clk_sys);
            fire <= 1'b1;
            @(posedge clk_sys);
            fire <= 1'b0;
            repeat (gap + 4) @(posedge clk_sys);
        end
    endtask : fire_n
    task automatic sync_pulse;
        @(posedge clk_sys);
        sev <= 32'h0000_0020;
        @(posedge clk_sys);
        sev <= 32'h0000_0000;
    endtask : sync_pulse
    // Bounded drain; also reads once more while empty
    task automatic drain(output int cnt);
        logic [15:0] s;
        cnt = 0;
        rd(ICP_OFS_CTRL_ONE, s);
        while (s[ICP_C1_BNE_BIT] === 1'b1 && cnt < 8) begin
            rd(ICP_OFS_FIFO_OUT, v[cnt]);
            cnt++;
            rd(ICP_OFS_CTRL_ONE, s);
        end
        rd(ICP_OFS_FIFO_OUT, s);
        cmp("empty fifo read", 16'h0000, s);
    endtask : drain
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        print_verdict();
    end

    // ==========================================
    // Main sequence
    initial begin
        seed = 32'h5e26;
        {errors, checks_done} = '0;
        {fire, sev, son, idle_hold} = '0;
        bus_req = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ICP_OFS_CTRL_ONE, d);
        cmp("ctrl one reset", ICP_C1_RESET, d);
        rd(ICP_OFS_CTRL_TWO, d);
        cmp("ctrl two reset", ICP_C2_RESET, d);
        rd(8'h10, d);
        cmp("unmapped read", 16'h0000, d);
        $display("done reset");
        wr(ICP_OFS_CTRL_ONE, 16'h1c23);
        rd(ICP_OFS_CTRL_ONE, d);
        cmp("ctrl one setup", 16'h1c23, d);
        wr(ICP_OFS_CTRL_TWO, 16'h0000);
        rd(ICP_OFS_CTRL_TWO, d);
        wr(ICP_OFS_COUNTER, 16'hfffe);
        ctr_step(d);
        cmp("step across wrap", 16'h0002, d);
        base = irqs;
        for (int i = 0; i < 4; i++) begin
            g[i] = 1 + ($random(seed) & 7);
            fire_n(1, g[i]);
        end
        cmp("irq count", 16'h0002, 16'(irqs - base));
        fire_n(1, 1);
        rd(ICP_OFS_CTRL_ONE, d);
        cmp("full flags", 16'h0018, d & 16'h0018);
        drain(n);
        cmp("fifo depth", 16'(ICP_FIFO_DEPTH), 16'(n));
        for (int i = 0; i < 3; i++) cmp("capture spacing", 16'(g[i] + 6), v[i + 1] - v[i]);
        rd(ICP_OFS_CTRL_ONE, d);
        cmp("flags after drain", 16'h0000, d & 16'h0018);
        $display("done fifo");
        for (int i = 0; i < 6; i++) begin
            wr(ICP_OFS_CTRL_ONE, 16'h1c00);
            wr(ICP_OFS_CTRL_ONE, 16'h1c00 | 16'(mt[i]));
            fire_n(pt[i], 1 + ($random(seed) & 3));
            drain(n);
            cmp("captures for mode", 16'(exp_caps(mt[i], pt[i])), 16'(n));
        end
        $display("done modes");
        wr(ICP_OFS_CTRL_TWO, 16'h0005);
        wr(ICP_OFS_CTRL_ONE, 16'h1c03);
        ctr_step(d);
        cmp("source off holds", 16'h0000, d);
        @(posedge clk_sys);
        son <= 32'h0000_0020;
        wr(ICP_OFS_COUNTER, 16'h8000);
        ctr_step(d);
        cmp("sync runs", 16'h0002, d);
        sync_pulse();
        rd(ICP_OFS_COUNTER, d);
        cmp("sync clears", 16'h0001, 16'(d < 16'h0008));
        wr(ICP_OFS_CTRL_TWO, 16'h0085);
        wr(ICP_OFS_COUNTER, 16'h1234);
        ctr_step(d);
        cmp("trigger wait", 16'h0000, d);
        sync_pulse();
        rd(ICP_OFS_CTRL_TWO, d);
        cmp("trigger status", 16'h0040, d & 16'h0040);
        ctr_step(d);
        cmp("triggered runs", 16'h0002, d);
        wr(ICP_OFS_CTRL_TWO, 16'h0080);
        ctr_step(d);
        cmp("software wait", 16'h0000, d);
        wr(ICP_OFS_CTRL_TWO, 16'h00c0);
        ctr_step(d);
        cmp("software start", 16'h0002, d);
        $display("done sync and trigger");
        wr(ICP_OFS_CTRL_TWO, 16'h0100);
        base = wraps;
        wr(ICP_OFS_COUNTER, 16'hfff8);
        repeat (12) @(posedge clk_sys);
        cmp("cascade wraps", 16'h0001, 16'(wraps - base));
        wr(ICP_OFS_CTRL_TWO, 16'h0000);
        wr(ICP_OFS_CTRL_ONE, 16'h3c03);
        @(posedge clk_sys);
        idle_hold <= 1'b1;
        ctr_step(d);
        cmp("idle halts", 16'h0000, d);
        wr(ICP_OFS_CTRL_ONE, 16'h1c03);
        idle_hold <= 1'b0;
        ctr_step(d);
        cmp("idle ignored", 16'h0002, d);
        $display("done cascade and idle");
        print_verdict();
    end
endmodule : icp_capture_test
